// ===== mtsc_sync_control.sv
`timescale 1ns/1ps
`default_nettype none
module mtsc_sync_control #(
    parameter int unsigned QF_CYC_30 = int'(mtsc_pkg::QF_CYC_30),
    parameter int unsigned QF_CYC_2997 = int'(mtsc_pkg::QF_CYC_2997),
    parameter int unsigned QF_CYC_25 = int'(mtsc_pkg::QF_CYC_25),
    parameter int unsigned QF_CYC_24 = int'(mtsc_pkg::QF_CYC_24),
    parameter int unsigned TC_LOSS_CYC = int'(mtsc_pkg::TC_LOSS_CYC)
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire mtsc_pkg::mtsc_rate_t timecode_rate_select_in,
    input wire logic sync_source_external_in,
    input wire mtsc_pkg::mtsc_gen_t sync_gen_select_in,
    input wire mtsc_pkg::mtsc_mmc_t mmc_mode_in,
    input wire logic [5:0] unit_identifier_in,
    input wire logic exclusive_receive_switch_in,
    input wire logic exclusive_transmit_switch_in,
    input wire logic out_port_echo_select_in,
    input wire logic play_condition_in,
    input wire logic local_play_in,
    input wire logic local_cmd_valid_in,
    input wire logic [7:0] local_cmd_in,
    input wire logic beat_tick_in,
    input wire mtsc_pkg::mtsc_byte_t recorded_beat_track_in,
    output logic recorded_beat_track_ready_out,
    input wire mtsc_pkg::mtsc_byte_t internal_msg_in,
    output logic internal_msg_ready_out,
    input wire mtsc_pkg::mtsc_tc_msg_t received_timecode_in,
    input wire mtsc_pkg::mtsc_byte_t midi_rx_in,
    input wire logic midi_tx_ready_in,
    output mtsc_pkg::mtsc_byte_t midi_tx_out,
    output mtsc_pkg::mtsc_tc_t timecode_out,
    output logic transport_run_out,
    output logic mmc_cmd_valid_out,
    output logic [7:0] mmc_cmd_out
);
    localparam int unsigned LOSS_W = $clog2(TC_LOSS_CYC + 1);

    mtsc_pkg::mtsc_byte_t tx;
    mtsc_pkg::mtsc_rx_state_t rx_state;
    mtsc_pkg::mtsc_tx_state_t tx_state;
    logic echo_sel;
    logic [31:0] qf_cnt;
    logic [31:0] qf_reload;
    logic [1:0] qf_phase;
    logic [2:0] piece;
    logic [LOSS_W-1:0] loss_cnt;
    logic beat_pend;
    logic qf_pend;
    logic mmc_pend;
    logic [7:0] mmc_cmd_hold;
    logic [7:0] rest [0:4];
    logic [2:0] rest_len;
    logic [2:0] rest_idx;
    logic [7:0] cmd_latch;
    mtsc_pkg::mtsc_tc_t tc;

    // the echo setting is sampled so a reset always restores the out function
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            echo_sel <= 1'b0;
        end else begin
            echo_sel <= out_port_echo_select_in;
        end
    end

    wire ext_sync = sync_source_external_in;
    wire tc_alive = (loss_cnt != '0);
    wire int_run = !ext_sync && local_play_in;
    wire qf_tick = int_run && (qf_cnt == 32'h0);
    wire frame_tick = qf_tick && (qf_phase == 2'h3);
    wire tc_load = ext_sync && received_timecode_in.valid;
    wire [7:0] id_byte = {2'b00, unit_identifier_in - 6'h01};
    wire mmc_tx_ok = (mmc_mode_in == mtsc_pkg::MMC_MASTER) && exclusive_transmit_switch_in
                     && !echo_sel;
    wire rx_ok = exclusive_receive_switch_in && play_condition_in
                 && (mmc_mode_in == mtsc_pkg::MMC_SLAVE);
    wire rx_v = midi_rx_in.valid;
    wire [7:0] rx_d = midi_rx_in.data;
    wire rx_status = rx_d[7] && (rx_d < mtsc_pkg::BYTE_REALTIME_MIN);

    assign qf_reload = (timecode_rate_select_in == mtsc_pkg::RATE_25) ? QF_CYC_25 - 32'h1 :
                       (timecode_rate_select_in == mtsc_pkg::RATE_24) ? QF_CYC_24 - 32'h1 :
                       (timecode_rate_select_in == mtsc_pkg::RATE_30) ? QF_CYC_30 - 32'h1 :
                       QF_CYC_2997 - 32'h1;

    // internal time base; received timecode cannot disturb it
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            qf_cnt <= 32'h0;
            qf_phase <= 2'h0;
        end else if (!int_run) begin
            qf_cnt <= qf_reload;
        end else begin
            qf_cnt <= qf_tick ? qf_reload : qf_cnt - 32'h1;
            qf_phase <= qf_tick ? qf_phase + 2'h1 : qf_phase;
        end
    end

    // loss watchdog: under external sync the transport halts once timecode stops arriving
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            loss_cnt <= '0;
        end else if (received_timecode_in.valid) begin
            loss_cnt <= LOSS_W'(TC_LOSS_CYC);
        end else if (tc_alive) begin
            loss_cnt <= loss_cnt - LOSS_W'(1);
        end
    end

    assign transport_run_out = ext_sync ? tc_alive : local_play_in;

    mtsc_frame_counter u_counter (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .advance_in(frame_tick),
        .load_in(tc_load),
        .load_value_in(received_timecode_in.tc),
        .rate_in(timecode_rate_select_in),
        .tc_out(tc)
    );
    assign timecode_out = tc;

    // quarter frame piece contents
    wire [1:0] rate_code = (timecode_rate_select_in == mtsc_pkg::RATE_24) ? mtsc_pkg::QF_CODE_24 :
                           (timecode_rate_select_in == mtsc_pkg::RATE_25) ? mtsc_pkg::QF_CODE_25 :
                           (timecode_rate_select_in == mtsc_pkg::RATE_2997_SKIPPING) ?
                           mtsc_pkg::QF_CODE_SKIP : mtsc_pkg::QF_CODE_30;
    logic [3:0] nib;
    always_comb begin
        case (piece)
            3'h0: nib = tc.frames[3:0];
            3'h1: nib = {3'h0, tc.frames[4]};
            3'h2: nib = tc.seconds[3:0];
            3'h3: nib = {2'h0, tc.seconds[5:4]};
            3'h4: nib = tc.minutes[3:0];
            3'h5: nib = {2'h0, tc.minutes[5:4]};
            3'h6: nib = tc.hours[3:0];
            default: nib = {1'b0, rate_code, tc.hours[4]};
        endcase
    end

    // transmit source selection, fixed priority, out function only
    wire can_load = !tx.valid || midi_tx_ready_in;
    wire pick = !echo_sel && can_load && (tx_state == mtsc_pkg::TX_IDLE);
    wire sel_beat = pick && beat_pend;
    wire sel_track = pick && !beat_pend && recorded_beat_track_in.valid
                     && (sync_gen_select_in == mtsc_pkg::GEN_RECORDED_TRACK);
    wire sel_qf = pick && !beat_pend && !sel_track && qf_pend;
    // a setting dropped while a message waits must stop it going out
    wire sel_mmc = pick && !beat_pend && !sel_track && !qf_pend && mmc_pend && mmc_tx_ok;
    wire sel_int = pick && !beat_pend && !sel_track && !qf_pend && !mmc_pend
                   && internal_msg_in.valid;
    wire send_rest = !echo_sel && can_load && (tx_state == mtsc_pkg::TX_SEND);
    assign recorded_beat_track_ready_out = sel_track;
    assign internal_msg_ready_out = sel_int;

    wire beat_ev = beat_tick_in && (sync_gen_select_in == mtsc_pkg::GEN_BEAT_CLOCK);
    wire qf_ev = qf_tick && (sync_gen_select_in == mtsc_pkg::GEN_TIMECODE);
    wire mmc_ev = local_cmd_valid_in && mmc_tx_ok;

    // a new event in the cycle its flag is taken keeps the flag set
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            beat_pend <= 1'b0;
            qf_pend <= 1'b0;
            mmc_pend <= 1'b0;
            mmc_cmd_hold <= 8'h00;
        end else begin
            beat_pend <= (beat_pend && !sel_beat) || beat_ev;
            qf_pend <= (qf_pend && !sel_qf) || qf_ev;
            mmc_pend <= ((mmc_pend && !sel_mmc) || mmc_ev) && mmc_tx_ok;
            mmc_cmd_hold <= mmc_ev ? local_cmd_in : mmc_cmd_hold;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            tx <= '0;
            tx_state <= mtsc_pkg::TX_IDLE;
            rest_len <= 3'h0;
            rest_idx <= 3'h0;
            piece <= 3'h0;
            for (int i = 0; i < 5; i++) begin
                rest[i] <= 8'h00;
            end
        end else if (echo_sel) begin
            tx <= rx_v ? midi_rx_in : '0;
            tx_state <= mtsc_pkg::TX_IDLE;
        end else if (send_rest) begin
            tx <= '{valid: 1'b1, data: rest[rest_idx]};
            rest_idx <= rest_idx + 3'h1;
            tx_state <= (rest_idx + 3'h1 == rest_len) ? mtsc_pkg::TX_IDLE : mtsc_pkg::TX_SEND;
        end else if (sel_beat) begin
            tx <= '{valid: 1'b1, data: mtsc_pkg::BYTE_BEAT_CLOCK};
        end else if (sel_track) begin
            tx <= recorded_beat_track_in;
        end else if (sel_qf) begin
            tx <= '{valid: 1'b1, data: mtsc_pkg::BYTE_QUARTER_FRAME};
            rest[0] <= {1'b0, piece, nib};
            rest_len <= 3'h1;
            rest_idx <= 3'h0;
            piece <= piece + 3'h1;
            tx_state <= mtsc_pkg::TX_SEND;
        end else if (sel_mmc) begin
            tx <= '{valid: 1'b1, data: mtsc_pkg::BYTE_SYSEX_START};
            rest[0] <= mtsc_pkg::BYTE_REALTIME_HDR;
            rest[1] <= id_byte;
            rest[2] <= mtsc_pkg::BYTE_MMC_COMMAND;
            rest[3] <= mmc_cmd_hold;
            rest[4] <= mtsc_pkg::BYTE_SYSEX_END;
            rest_len <= 3'h5;
            rest_idx <= 3'h0;
            tx_state <= mtsc_pkg::TX_SEND;
        end else if (sel_int) begin
            tx <= internal_msg_in;
        end else if (midi_tx_ready_in) begin
            tx.valid <= 1'b0;
        end
    end
    assign midi_tx_out = tx;

    // receive parser; real-time bytes may interleave and are stepped over
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rx_state <= mtsc_pkg::RX_IDLE;
            cmd_latch <= 8'h00;
            mmc_cmd_valid_out <= 1'b0;
            mmc_cmd_out <= 8'h00;
        end else begin
            mmc_cmd_valid_out <= 1'b0;
            if (rx_v && rx_d < mtsc_pkg::BYTE_REALTIME_MIN) begin
                case (rx_state)
                    mtsc_pkg::RX_IDLE: rx_state <= (rx_d == mtsc_pkg::BYTE_SYSEX_START && rx_ok) ?
                        mtsc_pkg::RX_HDR : mtsc_pkg::RX_IDLE;
                    mtsc_pkg::RX_HDR: rx_state <= (rx_d == mtsc_pkg::BYTE_REALTIME_HDR) ?
                        mtsc_pkg::RX_ID : mtsc_pkg::RX_IDLE;
                    mtsc_pkg::RX_ID: rx_state <= (rx_d == id_byte) ?
                        mtsc_pkg::RX_SUB : mtsc_pkg::RX_IDLE;
                    mtsc_pkg::RX_SUB: rx_state <= (rx_d == mtsc_pkg::BYTE_MMC_COMMAND) ?
                        mtsc_pkg::RX_CMD : mtsc_pkg::RX_IDLE;
                    mtsc_pkg::RX_CMD: begin
                        cmd_latch <= rx_d;
                        rx_state <= rx_status ? mtsc_pkg::RX_IDLE : mtsc_pkg::RX_END;
                    end
                    mtsc_pkg::RX_END: begin
                        if (rx_d == mtsc_pkg::BYTE_SYSEX_END && rx_ok) begin
                            mmc_cmd_valid_out <= 1'b1;
                            mmc_cmd_out <= cmd_latch;
                        end
                        rx_state <= mtsc_pkg::RX_IDLE;
                    end
                    default: rx_state <= mtsc_pkg::RX_IDLE;
                endcase
            end
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);

    a_echo_copy: assert property (echo_sel && rx_v |=> tx.valid && tx.data == $past(rx_d))
        else $error("echo byte not resent unchanged");
    a_mmc_gate: assert property (
        sel_mmc |-> mmc_mode_in == mtsc_pkg::MMC_MASTER
        && exclusive_transmit_switch_in && !echo_sel)
        else $error("exclusive sent while not allowed");
    a_mmc_frame: assert property (
        sel_mmc ##1 midi_tx_ready_in [*2]
        |=> tx.data == id_byte)
        else $error("outgoing identifier wrong");
    a_cmd_accept: assert property (
        mmc_cmd_valid_out |-> $past(rx_ok)
        && $past(rx_state == mtsc_pkg::RX_END))
        else $error("command accepted while receive not allowed");
    a_off_silent: assert property (
        mmc_mode_in == mtsc_pkg::MMC_OFF
        |-> !sel_mmc && (!$rose(mmc_cmd_valid_out) || $past(rx_ok)))
        else $error("machine control active while off");
    a_ext_halt: assert property (ext_sync && !tc_alive |-> !transport_run_out)
        else $error("transport ran without received timecode");
    a_int_base: assert property (
        !ext_sync |-> transport_run_out == local_play_in
        && !tc_load)
        else $error("internal sync disturbed by received timecode");
    a_int_ignore: assert property (
        !ext_sync && received_timecode_in.valid && !frame_tick
        |=> tc == $past(tc))
        else $error("received timecode moved the internal count");
    a_beat_byte: assert property (
        sel_beat |=> tx.valid
        && tx.data == mtsc_pkg::BYTE_BEAT_CLOCK)
        else $error("beat clock byte not sent");
    a_qf_pair: assert property (
        sel_qf ##1 midi_tx_ready_in
        |=> tx.valid && tx.data[7] == 1'b0 && tx.data[6:4] == $past(piece, 2))
        else $error("quarter frame data byte missing");
    a_int_pass: assert property (sel_int |=> tx == $past(internal_msg_in))
        else $error("internal message not passed out");
endmodule : mtsc_sync_control
`default_nettype wire

// ===== mtsc_pkg.sv
package mtsc_pkg;
    // timecode rate encodings
    typedef enum logic [2:0] {
        RATE_30 = 3'h0,
        RATE_2997_CONTINUOUS = 3'h1,
        RATE_2997_SKIPPING = 3'h2,
        RATE_25 = 3'h3,
        RATE_24 = 3'h4
    } mtsc_rate_t;

    typedef enum logic [1:0] {
        GEN_OFF = 2'h0,
        GEN_TIMECODE = 2'h1,
        GEN_BEAT_CLOCK = 2'h2,
        GEN_RECORDED_TRACK = 2'h3
    } mtsc_gen_t;

    typedef enum logic [1:0] {
        MMC_OFF = 2'h0,
        MMC_MASTER = 2'h1,
        MMC_SLAVE = 2'h2
    } mtsc_mmc_t;

    // exclusive receive parser, gray along the accepted path
    typedef enum logic [2:0] {
        RX_IDLE = 3'h0,
        RX_HDR = 3'h1,
        RX_ID = 3'h3,
        RX_SUB = 3'h2,
        RX_CMD = 3'h6,
        RX_END = 3'h7
    } mtsc_rx_state_t;

    typedef enum logic [1:0] {
        TX_IDLE = 2'h0,
        TX_SEND = 2'h1
    } mtsc_tx_state_t;

    typedef struct packed {
        logic [4:0] hours;
        logic [5:0] minutes;
        logic [5:0] seconds;
        logic [4:0] frames;
    } mtsc_tc_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } mtsc_byte_t;

    typedef struct packed {
        logic valid;
        mtsc_tc_t tc;
    } mtsc_tc_msg_t;

    // message bytes
    localparam logic [7:0] BYTE_SYSEX_START = 8'hf0;
    localparam logic [7:0] BYTE_SYSEX_END = 8'hf7;
    localparam logic [7:0] BYTE_QUARTER_FRAME = 8'hf1;
    localparam logic [7:0] BYTE_BEAT_CLOCK = 8'hf8;
    localparam logic [7:0] BYTE_REALTIME_HDR = 8'h7f;
    localparam logic [7:0] BYTE_MMC_COMMAND = 8'h06;
    localparam logic [7:0] BYTE_REALTIME_MIN = 8'hf8;

    // counting limits
    localparam logic [4:0] FRAME_MAX_30 = 5'h1d;
    localparam logic [4:0] FRAME_MAX_25 = 5'h18;
    localparam logic [4:0] FRAME_MAX_24 = 5'h17;
    localparam logic [4:0] FRAME_SKIP_FIRST = 5'h02;
    localparam logic [5:0] SEC_MAX = 6'h3b;
    localparam logic [5:0] MIN_MAX = 6'h3b;
    localparam logic [4:0] HOUR_MAX = 5'h17;
    localparam logic [5:0] MIN_NO_SKIP_STEP = 6'h0a;

    // quarter frame rate codes carried in the last piece
    localparam logic [1:0] QF_CODE_24 = 2'h0;
    localparam logic [1:0] QF_CODE_25 = 2'h1;
    localparam logic [1:0] QF_CODE_SKIP = 2'h2;
    localparam logic [1:0] QF_CODE_30 = 2'h3;

    // timing: clock rate, frame rates as num/den fps, four pieces per frame
    localparam longint CLK_HZ = 100_000_000;
    localparam longint QF_PER_FRAME = 4;
    localparam longint QF_CYC_30 = CLK_HZ / (30 * QF_PER_FRAME);
    localparam longint QF_CYC_2997 = CLK_HZ * 1001 / (30000 * QF_PER_FRAME);
    localparam longint QF_CYC_25 = CLK_HZ / (25 * QF_PER_FRAME);
    localparam longint QF_CYC_24 = CLK_HZ / (24 * QF_PER_FRAME);
    localparam longint TC_LOSS_MS = 100;
    localparam longint TC_LOSS_CYC = CLK_HZ / 1000 * TC_LOSS_MS;
endpackage : mtsc_pkg

// ===== mtsc_frame_counter.sv
`timescale 1ns/1ps
`default_nettype none
module mtsc_frame_counter (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic advance_in,
    input wire logic load_in,
    input wire mtsc_pkg::mtsc_tc_t load_value_in,
    input wire mtsc_pkg::mtsc_rate_t rate_in,
    output mtsc_pkg::mtsc_tc_t tc_out
);
    mtsc_pkg::mtsc_tc_t tc;
    mtsc_pkg::mtsc_tc_t next_tc;
    logic [4:0] frame_max;
    logic skip_rate;
    logic frame_wrap;
    logic sec_wrap;
    logic min_wrap;
    logic [5:0] next_min;
    logic skip_minute;

    assign frame_max = (rate_in == mtsc_pkg::RATE_25) ? mtsc_pkg::FRAME_MAX_25 :
                       (rate_in == mtsc_pkg::RATE_24) ? mtsc_pkg::FRAME_MAX_24 :
                       mtsc_pkg::FRAME_MAX_30;
    assign skip_rate = (rate_in == mtsc_pkg::RATE_2997_SKIPPING);
    assign frame_wrap = (tc.frames >= frame_max);
    assign sec_wrap = frame_wrap && (tc.seconds >= mtsc_pkg::SEC_MAX);
    assign min_wrap = sec_wrap && (tc.minutes >= mtsc_pkg::MIN_MAX);
    assign next_min = min_wrap ? 6'h00 : tc.minutes + 6'h01;
    // tens of minutes keep frames zero and one
    assign skip_minute = skip_rate && ((next_min % mtsc_pkg::MIN_NO_SKIP_STEP) != 6'h00);

    always_comb begin
        next_tc = tc;
        if (load_in) begin
            next_tc = load_value_in;
        end else if (advance_in) begin
            next_tc.frames = frame_wrap ? 5'h00 : tc.frames + 5'h01;
            if (frame_wrap) begin
                next_tc.seconds = sec_wrap ? 6'h00 : tc.seconds + 6'h01;
            end
            if (sec_wrap) begin
                next_tc.minutes = next_min;
                next_tc.frames = skip_minute ? mtsc_pkg::FRAME_SKIP_FIRST : 5'h00;
            end
            if (min_wrap) begin
                next_tc.hours = (tc.hours >= mtsc_pkg::HOUR_MAX) ? 5'h00 : tc.hours + 5'h01;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            tc <= '0;
        end else begin
            tc <= next_tc;
        end
    end

    assign tc_out = tc;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);

    a_skip_new_minute: assert property (
        advance_in && !load_in && sec_wrap && skip_minute
        |=> tc.frames == 5'h02 && tc.seconds == 6'h00)
        else $error("skipping minute did not start at frame two");
    a_plain_new_minute: assert property (
        advance_in && !load_in && sec_wrap && !skip_rate
        |=> tc.frames == 5'h00)
        else $error("non-skipping rate dropped frames");
    a_frame_step: assert property (
        advance_in && !load_in && !frame_wrap
        |=> tc.frames == $past(tc.frames) + 5'h01)
        else $error("frame count skipped a value");
endmodule : mtsc_frame_counter
`default_nettype wire

// ===== mtsc_seq_model.sv
`timescale 1ns/1ps
`default_nettype none
module mtsc_seq_model (
    input wire logic clk_in,
    input wire logic stall_in,
    input wire mtsc_pkg::mtsc_byte_t tx_in,
    output logic ready_out,
    output mtsc_pkg::mtsc_byte_t rx_out,
    output mtsc_pkg::mtsc_tc_msg_t tc_out
);
    logic [7:0] got[$];
    logic ph = 1'b0;
    initial begin
        rx_out = '0;
        tc_out = '0;
    end
    // a slow partner takes a byte only every other cycle
    always @(negedge clk_in) ph <= ~ph;
    assign ready_out = !stall_in || ph;
    always @(posedge clk_in) if (tx_in.valid && ready_out) got.push_back(tx_in.data);
    // a released line shows the inverse so a stale byte never matches
    task automatic send_byte(input logic [7:0] b);
        @(negedge clk_in) rx_out <= {1'b1, b};
        @(negedge clk_in) rx_out <= {1'b0, ~b};
    endtask : send_byte
    task automatic send_tc(input mtsc_pkg::mtsc_tc_t t);
        @(negedge clk_in) tc_out <= {1'b1, t};
        @(negedge clk_in) tc_out <= {1'b0, ~t};
    endtask : send_tc
endmodule : mtsc_seq_model
`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk_in = 1'b0;
    logic rstn_in = 1'b0;
    mtsc_pkg::mtsc_rate_t rate = mtsc_pkg::RATE_30;
    mtsc_pkg::mtsc_gen_t gen = mtsc_pkg::GEN_OFF;
    mtsc_pkg::mtsc_mmc_t mmc = mtsc_pkg::MMC_OFF;
    mtsc_pkg::mtsc_byte_t trk = '0, imsg = '0, rx, tx;
    mtsc_pkg::mtsc_tc_msg_t tcm;
    mtsc_pkg::mtsc_tc_t tco, t;
    logic [5:0] id = 6'h01;
    logic received_timecode_reference = 1'b0, rxsw = 1'b0, txsw = 1'b0, echo = 1'b0, play = 1'b0, lplay = 1'b0;
    logic lcv = 1'b0, beat = 1'b0;
    logic stall = 1'b1;
    logic [2:0] pc = 3'h0;
    logic trk_rdy, imsg_rdy, rdy, run, mv;
    logic [7:0] lcmd = '0, mcmd, c, lastc;
    logic [7:0] want[$];
    int failures = 0, samples_checked = 0, nm = 0, n0, i, j, k;
    integer seed = 32'hc9fed105;
    always #5 clk_in = ~clk_in;
    always @(posedge clk_in) if (mv) begin
        nm++;
        lastc = mcmd;
    end
    mtsc_sync_control #(.QF_CYC_30(8), .QF_CYC_2997(8), .QF_CYC_25(8), .QF_CYC_24(8),
        .TC_LOSS_CYC(50)) u_mtsc_sync_control (.clk_in, .rstn_in,
        .timecode_rate_select_in(rate), .sync_source_external_in(received_timecode_reference), .sync_gen_select_in(gen),
        .mmc_mode_in(mmc), .unit_identifier_in(id), .exclusive_receive_switch_in(rxsw),
        .exclusive_transmit_switch_in(txsw), .out_port_echo_select_in(echo),
        .play_condition_in(play), .local_play_in(lplay), .local_cmd_valid_in(lcv),
        .local_cmd_in(lcmd), .beat_tick_in(beat), .recorded_beat_track_in(trk),
        .recorded_beat_track_ready_out(trk_rdy), .internal_msg_in(imsg),
        .internal_msg_ready_out(imsg_rdy), .received_timecode_in(tcm), .midi_rx_in(rx),
        .midi_tx_ready_in(rdy), .midi_tx_out(tx), .timecode_out(tco),
        .transport_run_out(run), .mmc_cmd_valid_out(mv), .mmc_cmd_out(mcmd));
    mtsc_seq_model u_mtsc_seq_model (.clk_in, .stall_in(stall), .tx_in(tx),
        .ready_out(rdy), .rx_out(rx), .tc_out(tcm));
    function automatic logic [4:0] fmax(input mtsc_pkg::mtsc_rate_t r);
        return r == mtsc_pkg::RATE_25 ? 5'h18 : r == mtsc_pkg::RATE_24 ? 5'h17 : 5'h1d;
    endfunction : fmax
    function automatic logic [1:0] qcode(input mtsc_pkg::mtsc_rate_t r);
        return r == mtsc_pkg::RATE_24 ? mtsc_pkg::QF_CODE_24 : r == mtsc_pkg::RATE_25 ?
            mtsc_pkg::QF_CODE_25 : r == mtsc_pkg::RATE_2997_SKIPPING ? mtsc_pkg::QF_CODE_SKIP :
            mtsc_pkg::QF_CODE_30;
    endfunction : qcode
    function automatic mtsc_pkg::mtsc_tc_t nxt(input mtsc_pkg::mtsc_tc_t a,
                                                input mtsc_pkg::mtsc_rate_t r);
        a.frames = (a.frames == fmax(r)) ? 5'h00 : a.frames + 5'h01;
        if (a.frames == 5'h00) a.seconds = (a.seconds == 6'h3b) ? 6'h00 : a.seconds + 6'h01;
        if (a.frames == 5'h00 && a.seconds == 6'h00) begin
            a.minutes = a.minutes + 6'h01;
            if (r == mtsc_pkg::RATE_2997_SKIPPING && a.minutes % 10 != 0) a.frames = 5'h02;
        end
        return a;
    endfunction : nxt
    task automatic final_report();
        if (failures == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : final_report
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
        end
    endtask : check
    task automatic drain();
        for (i = 0; i < 300 && u_mtsc_seq_model.got.size() < want.size(); i++) @(posedge clk_in);
        if (u_mtsc_seq_model.got.size() < want.size()) begin
            failures++;
            final_report();
        end
        repeat (20) @(posedge clk_in);
        check(u_mtsc_seq_model.got.size(), want.size());
        foreach (want[q]) check(u_mtsc_seq_model.got[q], want[q]);
        u_mtsc_seq_model.got.delete();
        want.delete();
        @(negedge clk_in);
    endtask : drain
    // source byte is held until the edge that takes it
    task automatic offer(input logic sel, input logic [7:0] b);
        @(negedge clk_in);
        if (sel) trk <= {1'b1, b};
        else imsg <= {1'b1, b};
        for (i = 0; i < 50; i++) begin
            #1;
            if (sel ? trk_rdy : imsg_rdy) break;
            @(negedge clk_in);
        end
        @(negedge clk_in);
        trk <= '0;
        imsg <= '0;
        if (i == 50) begin
            failures++;
            final_report();
        end
    endtask : offer
    initial begin
        repeat (6) @(negedge clk_in);
        rstn_in = 1'b1;
        offer(1'b0, 8'h90);
        want = '{8'h90};
        drain();
        for (j = 0; j < 2; j++) begin
            gen <= j ? mtsc_pkg::GEN_OFF : mtsc_pkg::GEN_BEAT_CLOCK;
            @(negedge clk_in) beat <= 1'b1;
            @(negedge clk_in) beat <= 1'b0;
            if (j == 0) want = '{8'hf8};
            drain();
        end
        gen <= mtsc_pkg::GEN_RECORDED_TRACK;
        c = 8'($random(seed));
        offer(1'b1, c);
        want = '{c};
        drain();
        gen <= mtsc_pkg::GEN_OFF;
        // back-to-back ready lets the whole outgoing frame be watched
        stall <= 1'b0;
        // identifier corners first, then random; last two refused
        for (j = 0; j < 5; j++) begin
            mmc <= j == 4 ? mtsc_pkg::MMC_OFF : mtsc_pkg::MMC_MASTER;
            txsw <= j != 3;
            id <= j == 0 ? 6'h01 : j == 1 ? 6'h20 : 6'(($random(seed) & 31) + 1);
            c = 8'($random(seed)) & 8'h7f;
            @(negedge clk_in) lcv <= 1'b1;
            lcmd <= c;
            @(negedge clk_in) lcv <= 1'b0;
            if (j < 3) want = '{8'hf0, 8'h7f, 8'(id - 6'h01), 8'h06, c, 8'hf7};
            drain();
        end
        for (k = 0; k < 5; k++) begin
            mmc <= k == 4 ? mtsc_pkg::MMC_OFF : mtsc_pkg::MMC_SLAVE;
            rxsw <= k != 2;
            play <= k != 3;
            c = 8'($random(seed)) & 8'h7f;
            n0 = nm;
            want = '{8'hf0, 8'h7f, k == 1 ? 8'(id) : 8'(id - 6'h01), 8'h06, c, 8'hf7};
            foreach (want[q]) u_mtsc_seq_model.send_byte(want[q]);
            want.delete();
            repeat (4) @(negedge clk_in);
            check(nm, n0 + (k == 0));
            if (k == 0) check(lastc, c);
        end
        mmc <= mtsc_pkg::MMC_OFF;
        echo <= 1'b1;
        stall <= 1'b0;
        repeat (2) @(negedge clk_in);
        for (k = 0; k < 8; k++) begin
            c = 8'($random(seed));
            u_mtsc_seq_model.send_byte(c);
            want.push_back(c);
        end
        drain();
        echo <= 1'b0;
        gen <= mtsc_pkg::GEN_TIMECODE;
        for (k = 0; k < 10; k++) begin
            rate <= mtsc_pkg::mtsc_rate_t'(k / 2);
            received_timecode_reference <= 1'b1;
            @(negedge clk_in);
            t = {5'h00, k[0] ? 6'h09 : 6'h00, 6'h3b, fmax(rate)};
            u_mtsc_seq_model.send_tc(t);
            repeat (2) @(negedge clk_in);
            check(tco, t);
            check(run, 1'b1);
            repeat (60) @(negedge clk_in);
            check(run, 1'b0);
            received_timecode_reference <= 1'b0;
            lplay <= 1'b1;
            for (i = 0; i < 100 && tco === t; i++) @(negedge clk_in);
            if (tco === t) begin
                failures++;
                final_report();
            end
            lplay <= 1'b0;
            check(tco, nxt(t, rate));
            u_mtsc_seq_model.send_tc(22'($random(seed)));
            repeat (2) @(negedge clk_in);
            check(tco, nxt(t, rate));
            check(u_mtsc_seq_model.got.size() % 2, 0);
            check(u_mtsc_seq_model.got.size() != 0, 1'b1);
            for (j = 0; j < u_mtsc_seq_model.got.size(); j++) begin
                c = u_mtsc_seq_model.got[j];
                if (j % 2 == 0) begin
                    check(c, 8'hf1);
                end else begin
                    check(c[7:4], {1'b0, pc});
                    if (pc >= 3'h6)
                        check(c[3:0], pc[0] ? {1'b0, qcode(rate), 1'b0} : 4'h0);
                    pc++;
                end
            end
            u_mtsc_seq_model.got.delete();
        end
        final_report();
    end
endmodule : tb_top
`default_nettype wire
